// file: pkg/rcs_pkg.sv
// Contract
// - reads give cause, writes arm sources or force a soft reset
// - bit 6 set on flash fault reset
// - bit 5 reads comparator-caused reset
// - write bit 5 arms active-low comparator
// - write bit 4 forces system reset now
// - bit 4 reads one only after soft reset
// - bit 3 set on watchdog overflow reset
// - bit 2 reads clock-loss caused reset
// - write bit 2 arms clock-loss detector reset
// - bit 1 reads power-on or supply reset
// - write bit 1 selects supply monitor source
// - other flags meaningless while bit 1 set
// - bit 0 set on external pin reset
// - supply resets need enable and selection
package rcs_pkg;

  localparam logic [7:0] RESET_CAUSE_REG_ADDR = 8'hEF;

  localparam int BIT_RESERVED = 7;
  localparam int BIT_FLASH = 6;
  localparam int BIT_CMP = 5;
  localparam int BIT_SOFT = 4;
  localparam int BIT_WDT = 3;
  localparam int BIT_CLK_LOSS = 2;
  localparam int BIT_SUPPLY = 1;
  localparam int BIT_PIN = 0;

  // one-hot cause codes as stored in the flag field
  localparam logic [6:0] CAUSE_NONE = 7'h00;
  localparam logic [6:0] CAUSE_PIN = 7'h01;
  localparam logic [6:0] CAUSE_SUPPLY = 7'h02;
  localparam logic [6:0] CAUSE_CLK_LOSS = 7'h04;
  localparam logic [6:0] CAUSE_WDT = 7'h08;
  localparam logic [6:0] CAUSE_SOFT = 7'h10;
  localparam logic [6:0] CAUSE_CMP = 7'h20;
  localparam logic [6:0] CAUSE_FLASH = 7'h40;
  localparam logic [6:0] FLAGS_POR_VALUE = CAUSE_SUPPLY;

  localparam int CLK_PERIOD_NS = 8;
  localparam int MCD_TIMEOUT_NS = 1000;
  localparam int MCD_CYCLES = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int RST_HOLD_NS = 128;
  localparam int RST_HOLD_CYCLES = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 8;
  localparam int MCD_W = 8;

  typedef enum logic [0:0] {
    RCS_RUN = 1'b0,
    RCS_HOLD = 1'b1
  } rcs_phase_e;

  typedef struct packed {
    logic pin_req;
    logic wdt_ovf;
    logic flash_err;
    logic cmp0_out;
    logic supply_low;
    logic clk_alive;
  } rcs_src_s;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } rcs_sfr_req_s;

  typedef struct packed {
    rcs_phase_e phase;
    logic [HOLD_W-1:0] hold_cnt;
    logic [6:0] flags;
    logic en_cmp;
    logic en_mcd;
    logic en_supply;
    logic [7:0] rdata;
    logic sys_reset;
  } rcs_top_state_s;

  typedef struct packed {
    logic [MCD_W-1:0] idle_cnt;
    logic timeout;
  } rcs_mcd_state_s;

endpackage

// file: hw/rcs_clock_watch.sv
`timescale 1ns/10ps
module rcs_clock_watch (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic alive_tick,
  output logic timeout
);

  rcs_pkg::rcs_mcd_state_s st_r;
  rcs_pkg::rcs_mcd_state_s st_nxt;

  localparam logic [rcs_pkg::MCD_W-1:0] LAST =
    rcs_pkg::MCD_W'(rcs_pkg::MCD_CYCLES - 1);

  // the watched oscillator announces itself by ticks; a long silence means it stopped
  always_comb begin
    st_nxt = st_r;
    st_nxt.timeout = 1'b0;
    if (!enable || alive_tick) begin
      st_nxt.idle_cnt = '0;
    end else if (st_r.idle_cnt == LAST) begin
      st_nxt.idle_cnt = '0;
      st_nxt.timeout = 1'b1;
    end else begin
      st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timeout = st_r.timeout;

  mcd_fires_a: assert property (@(posedge clk) disable iff (rst)
    (enable && !alive_tick && st_r.idle_cnt == LAST) |=> timeout)
    else $error("clock loss timeout missing");

  mcd_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!enable || alive_tick) |=> !timeout)
    else $error("clock loss timeout while disabled or alive");

endmodule

// file: hw/rcs_reset_cause.sv
`timescale 1ns/10ps
module rcs_reset_cause (
  input wire logic clk,
  input wire logic rst,
  input rcs_pkg::rcs_sfr_req_s sfr,
  input rcs_pkg::rcs_src_s src,
  input wire logic supply_watch_enable,
  output logic [7:0] sfr_rdata,
  output logic sys_reset_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state and decode

  rcs_pkg::rcs_top_state_s st_r;
  rcs_pkg::rcs_top_state_s st_nxt;

  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic running;
  logic mcd_timeout;
  logic [6:0] cause_v;
  logic [6:0] cause_pick;

  localparam logic [rcs_pkg::HOLD_W-1:0] HOLD_LAST =
    rcs_pkg::HOLD_W'(rcs_pkg::RST_HOLD_CYCLES - 1);

  // lowest bit wins: the pin outranks everything, flash fault ranks last
  function automatic logic [6:0] first_cause(input logic [6:0] req);
    logic [6:0] pick;
    pick = 7'h00;
    for (int i = 6; i >= 0; i--) begin
      if (req[i]) begin
        pick = 7'h00;
        pick[i] = 1'b1;
      end
    end
    return pick;
  endfunction

  assign hit = (sfr.addr == rcs_pkg::RESET_CAUSE_REG_ADDR);
  assign wr_hit = hit && sfr.wr;
  assign rd_hit = hit && sfr.rd;
  assign running = (st_r.phase == rcs_pkg::RCS_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  rcs_clock_watch u_clock_loss_detector (
    .clk(clk),
    .rst(rst),
    .enable(st_r.en_mcd && running),
    .alive_tick(src.clk_alive),
    .timeout(mcd_timeout)
  );

  always_comb begin
    cause_v = 7'h00;
    cause_v[rcs_pkg::BIT_PIN] = src.pin_req;
    // supply reset only when both the monitor and the selection are on
    cause_v[rcs_pkg::BIT_SUPPLY] =
      src.supply_low && st_r.en_supply && supply_watch_enable;
    cause_v[rcs_pkg::BIT_CLK_LOSS] = mcd_timeout;
    cause_v[rcs_pkg::BIT_WDT] = src.wdt_ovf;
    cause_v[rcs_pkg::BIT_SOFT] = wr_hit && sfr.wdata[rcs_pkg::BIT_SOFT];
    cause_v[rcs_pkg::BIT_CMP] = st_r.en_cmp && !src.cmp0_out;
    cause_v[rcs_pkg::BIT_FLASH] = src.flash_err;
  end

  assign cause_pick = first_cause(cause_v);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    if (rd_hit) begin
      // reads see the cause flags, never the arming bits
      st_nxt.rdata = {1'b0, st_r.flags};
    end
    case (st_r.phase)
      rcs_pkg::RCS_RUN: begin
        if (cause_v != rcs_pkg::CAUSE_NONE) begin
          // one flag per reset, the rest cleared
          st_nxt.flags = cause_pick;
          st_nxt.phase = rcs_pkg::RCS_HOLD;
          st_nxt.hold_cnt = HOLD_LAST;
          st_nxt.sys_reset = 1'b1;
          // a system reset disarms the sources; software re-arms them
          st_nxt.en_cmp = 1'b0;
          st_nxt.en_mcd = 1'b0;
          st_nxt.en_supply = 1'b0;
        end else if (wr_hit) begin
          // writes touch only the arming bits, bit 7 is dropped
          st_nxt.en_cmp = sfr.wdata[rcs_pkg::BIT_CMP];
          st_nxt.en_mcd = sfr.wdata[rcs_pkg::BIT_CLK_LOSS];
          st_nxt.en_supply = sfr.wdata[rcs_pkg::BIT_SUPPLY];
        end
      end
      rcs_pkg::RCS_HOLD: begin
        // flags are left alone so they are still there after release
        if (st_r.hold_cnt == '0) begin
          st_nxt.phase = rcs_pkg::RCS_RUN;
          st_nxt.sys_reset = 1'b0;
        end else begin
          st_nxt.hold_cnt = st_r.hold_cnt - 1'b1;
        end
      end
      default: begin
        st_nxt.phase = rcs_pkg::RCS_RUN;
        st_nxt.sys_reset = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // rst is the power-on reset; it loads the flags with the supply flag (FLAGS_POR_VALUE)
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.phase <= rcs_pkg::RCS_RUN;
      st_r.hold_cnt <= '0;
      st_r.flags <= rcs_pkg::FLAGS_POR_VALUE;
      st_r.en_cmp <= 1'b0;
      st_r.en_mcd <= 1'b0;
      st_r.en_supply <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.sys_reset <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata = st_r.rdata;
  assign sys_reset_out = st_r.sys_reset;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  read_gives_flags_a: assert property (
    rd_hit |=> sfr_rdata == {1'b0, $past(st_r.flags)})
    else $error("read did not return cause flags");

  reserved_zero_a: assert property (
    rd_hit |=> !sfr_rdata[rcs_pkg::BIT_RESERVED])
    else $error("reserved bit read as one");

  write_keeps_flags_a: assert property (
    running && wr_hit && cause_v == rcs_pkg::CAUSE_NONE |=> $stable(st_r.flags))
    else $error("write changed cause flags");

  soft_reset_now_a: assert property (
    running && wr_hit && sfr.wdata[rcs_pkg::BIT_SOFT] |=> sys_reset_out)
    else $error("soft reset not forced");

  soft_flag_only_a: assert property (
    running && cause_v == rcs_pkg::CAUSE_SOFT |=> st_r.flags == rcs_pkg::CAUSE_SOFT)
    else $error("soft reset flag wrong");

  single_cause_a: assert property (
    running && cause_v != rcs_pkg::CAUSE_NONE |=> $onehot(st_r.flags))
    else $error("more than one cause latched");

  pin_wins_a: assert property (
    running && src.pin_req |=> st_r.flags == rcs_pkg::CAUSE_PIN)
    else $error("pin reset not recorded");

  watchdog_flag_a: assert property (
    running && cause_v == rcs_pkg::CAUSE_WDT |=> st_r.flags == rcs_pkg::CAUSE_WDT)
    else $error("watchdog reset not recorded");

  flash_flag_a: assert property (
    running && cause_v == rcs_pkg::CAUSE_FLASH |=> st_r.flags == rcs_pkg::CAUSE_FLASH)
    else $error("flash fault reset not recorded");

  clock_loss_flag_a: assert property (
    running && cause_v == rcs_pkg::CAUSE_CLK_LOSS
      |=> st_r.flags == rcs_pkg::CAUSE_CLK_LOSS && sys_reset_out)
    else $error("clock loss reset not recorded");

  comparator_reset_a: assert property (
    running && st_r.en_cmp && !src.cmp0_out && cause_v[4:0] == 5'h00
      |=> st_r.flags == rcs_pkg::CAUSE_CMP && sys_reset_out)
    else $error("comparator reset not recorded");

  comparator_armed_a: assert property (
    running && wr_hit && cause_v == rcs_pkg::CAUSE_NONE
      |=> st_r.en_cmp == $past(sfr.wdata[rcs_pkg::BIT_CMP]))
    else $error("comparator arming not taken");

  supply_flag_a: assert property (
    running && cause_v == rcs_pkg::CAUSE_SUPPLY |=> st_r.flags == rcs_pkg::CAUSE_SUPPLY)
    else $error("supply reset not recorded");

  supply_gated_a: assert property (
    running && !(st_r.en_supply && supply_watch_enable)
      && (cause_v & 7'h7D) == 7'h00 |=> !sys_reset_out)
    else $error("supply reset without enable and selection");

  hold_length_a: assert property (
    $rose(sys_reset_out) |-> (sys_reset_out throughout ##15 1'b1) ##1 !sys_reset_out)
    else $error("system reset pulse length wrong");

  flags_survive_a: assert property (
    st_r.phase == rcs_pkg::RCS_HOLD |=> $stable(st_r.flags))
    else $error("cause flags lost during system reset");

endmodule

// file: bench/rcs_src_model.sv
`timescale 1ns/10ps
module rcs_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] go,
  input wire logic cmp_low,
  input wire logic supply_low,
  input wire logic watch_en,
  input wire logic clk_stop,
  input wire logic sys_reset,
  output rcs_pkg::rcs_src_s src,
  output logic supply_watch_enable
);
  logic [2:0] pend_r;
  logic [1:0] tick_r;
  // sources keep asking until the reset answers, as real faults do
  always_ff @(posedge clk) begin
    if (rst || sys_reset) begin
      pend_r <= 3'h0;
    end else begin
      pend_r <= pend_r | go;
    end
    tick_r <= rst ? 2'h0 : tick_r + 2'h1;
  end
  ////////////////////////////////////////////////////////////////
  assign src.pin_req = pend_r[0];
  assign src.wdt_ovf = pend_r[1];
  assign src.flash_err = pend_r[2];
  assign src.cmp0_out = !cmp_low;
  assign src.supply_low = supply_low;
  assign src.clk_alive = !clk_stop && (tick_r == 2'h0);
  assign supply_watch_enable = watch_en;
endmodule

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rcs_pkg::rcs_sfr_req_s sfr = '0;
  rcs_pkg::rcs_src_s src;
  logic [2:0] go = 3'h0;
  logic cmp_low = 1'b0;
  logic supply_low = 1'b0;
  logic watch_en = 1'b0;
  logic clk_stop = 1'b0;
  logic supply_watch_enable;
  logic sys_reset_out;
  logic [7:0] sfr_rdata;
  int miscompares = 0;
  int checked = 0;

  rcs_reset_cause u_rcs_reset_cause (.clk(clk), .rst(rst), .sfr(sfr), .src(src),
    .supply_watch_enable(supply_watch_enable), .sfr_rdata(sfr_rdata),
    .sys_reset_out(sys_reset_out));
  rcs_src_model u_rcs_src_model (.clk(clk), .rst(rst), .go(go), .cmp_low(cmp_low),
    .supply_low(supply_low), .watch_en(watch_en), .clk_stop(clk_stop),
    .sys_reset(sys_reset_out), .src(src), .supply_watch_enable(supply_watch_enable));

  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
    sfr = '{addr: a, rd: !w, wr: w, wdata: d};
    cyc(1);
    sfr = '0;
  endtask

  // read data only stands one cycle, so it is sampled right after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    access(a, 1'b0, 8'h00);
    chk8(sfr_rdata, exp, what);
    cyc(1);
    chk8(sfr_rdata, 8'h00, "read data lingers");
  endtask

  // whole-byte writes only: read value and write meaning differ
  task automatic wr(input logic [7:0] d);
    access(8'hEF, 1'b1, d);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      chk8({7'h00, sys_reset_out}, 8'h00, "unexpected reset");
      cyc(1);
    end
  endtask

  task automatic expect_reset(input int limit, input logic [7:0] cause);
    int n;
    n = 0;
    while (sys_reset_out !== 1'b1 && n < limit) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (sys_reset_out === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk8(8'(n), 8'(rcs_pkg::RST_HOLD_CYCLES), "reset length");
    rd(8'hEF, cause, "cause flag");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_power_on();
    rd(8'hEF, 8'h02, "power-on flag");
    rd(8'h3C, 8'h00, "unmapped read");
  endtask

  task automatic t_soft();
    wr(8'h10);
    expect_reset(0, 8'h10);
  endtask

  // last entry raises two causes at once; only one flag may remain
  task automatic t_events();
    logic [2:0] kick [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    logic [7:0] exp [4] = '{8'h01, 8'h08, 8'h40, 8'h01};
    for (int i = 0; i < 4; i++) begin
      go = kick[i];
      cyc(1);
      go = 3'h0;
      expect_reset(4, exp[i]);
    end
  endtask

  task automatic t_cmp();
    cmp_low = 1'b1;
    quiet(4);
    wr(8'h20);
    expect_reset(4, 8'h20);
    quiet(2);
    cmp_low = 1'b0;
  endtask

  task automatic t_supply();
    supply_low = 1'b1;
    wr(8'h02);
    quiet(4);
    wr(8'h00);
    watch_en = 1'b1;
    quiet(8);
    wr(8'h02);
    expect_reset(4, 8'h02);
    supply_low = 1'b0;
  endtask

  task automatic t_clock_loss();
    wr(8'h04);
    quiet(40);
    clk_stop = 1'b1;
    quiet(110);
    expect_reset(30, 8'h04);
    clk_stop = 1'b0;
  endtask

  task automatic t_write_side();
    wr(8'h26);
    quiet(2);
    rd(8'hEF, 8'h04, "flags moved on write");
    wr(8'h00);
    cyc(1);
    // a soft reset request to another address must not reach this register
    access(8'h3C, 1'b1, 8'h10);
    quiet(2);
    // a second power-on reset replaces the old cause with the power-on flag
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(8'hEF, 8'h02, "flags after second power-on");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst = 1'b0;
    t_power_on();
    t_soft();
    t_events();
    t_cmp();
    t_supply();
    t_clock_loss();
    t_write_side();
    test_done();
  end

  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule
